// [shared/l1cp_pkg.sv]
// shared constants and types for the l1 cache policy controller
package l1cp_pkg;
    localparam int LINE_WORDS = 8;
    localparam int WORD_IDX_W = 3;
    localparam int SETS = 64;
    localparam int WAYS = 4;
    localparam int SET_W = 6;
    localparam int WAY_W = 2;
    localparam int THR_W = 4;
    localparam int HIT_CNT_W = 4;
    localparam logic [THR_W-1:0] STREAM_THR_RST = 4'h8;
    localparam logic [HIT_CNT_W-1:0] HIT_EXIT_RST = 4'h6;

    typedef enum logic [1:0]
    {
        L1CP_INVALID = 2'h0,
        L1CP_SHARED = 2'h1,
        L1CP_EXCL = 2'h2,
        L1CP_MOD = 2'h3
    } l1cp_mesi_t;

    typedef enum logic [1:0]
    {
        L1CP_DEST_L2 = 2'h0,
        L1CP_DEST_L3 = 2'h1,
        L1CP_DEST_SYS = 2'h2
    } l1cp_dest_t;

    typedef enum logic [1:0]
    {
        L1CP_MNT_INVAL_ADDR = 2'h0,
        L1CP_MNT_CLEAN_INVAL_ADDR = 2'h1,
        L1CP_MNT_INVAL_ADDR32 = 2'h2,
        L1CP_MNT_INVAL_SETWAY = 2'h3
    } l1cp_mnt_t;
endpackage : l1cp_pkg

// [hdl/l1cp_wsm.sv]
// write streaming mode detector
`timescale 1ns/10ps
module l1cp_wsm #(
    parameter int THR_W = l1cp_pkg::THR_W,
    parameter int HIT_CNT_W = l1cp_pkg::HIT_CNT_W
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic full_line_pending,
    input wire logic linefill_busy,
    input wire logic full_line_zero_op,
    input wire logic no_resource,
    input wire logic store_valid,
    input wire logic store_hit,
    input wire logic [HIT_CNT_W-1:0] hit_exit,
    output logic active
);
    typedef struct packed
    {
        logic active;
        logic [HIT_CNT_W-1:0] hits;
    } l1cp_wsm_st_t;

    l1cp_wsm_st_t st;
    l1cp_wsm_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (st.active)
        begin
            if (store_valid)
            begin
                // hits climb, misses decay: a hit-heavy mix ends streaming
                if (store_hit)
                    next_st.hits = st.hits + 1'b1;
                else if (st.hits != '0)
                    next_st.hits = st.hits - 1'b1;
            end
            if (no_resource || (next_st.hits >= hit_exit))
            begin
                next_st.active = 1'b0;
                next_st.hits = '0;
            end
        end
        else if ((full_line_pending && linefill_busy) || full_line_zero_op)
        begin
            next_st.active = 1'b1;
            next_st.hits = '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign active = st.active;
endmodule : l1cp_wsm

// [hdl/l1cp_top.sv]
// l1 cache policy controller: enables, routing, maintenance, streaming
// Notes on behaviour
// - caches come up disabled and are invalidated after reset release.
// - skip reset invalidation when power mode is debug recovery.
// - separate instruction and data enables; no line locking exists.
// - linefills request critical word first then remaining words.
// - disabled icache sees no fetch array access; maintenance still runs.
// - fetches with icache disabled go out non-cacheable.
// - fetches to device pages act as normal non-cacheable.
// - icache miss may look up dcache; allocate only if dcache enabled.
// - with dcache disabled loads/stores touch no L1, L2 or L3 array.
// - fetches allocate in L2/L3 only when dcache is enabled.
// - data maintenance runs even when the data cache is disabled.
// - loads/stores with dcache disabled are issued non-cacheable.
// - L1 data cache and L2 share one enable.
// - 64-bit invalidate by address runs as clean-and-invalidate.
// - invalidate by address cleans dirty data first.
// - set/way invalidate cleans then invalidates; override bit ignored.
// - data cache allocates on read miss and on write miss.
// - streaming entered on full line stores during linefill or zeroing.
// - streaming: loads normal, store misses go downstream, no linefill.
// - streaming ends on lack of resources or many store hits.
// - stream destination thresholds come from extended control register.
`timescale 1ns/10ps
module l1cp_top #(
    parameter int SETS = l1cp_pkg::SETS,
    parameter int SET_W = l1cp_pkg::SET_W,
    parameter int WAY_W = l1cp_pkg::WAY_W,
    parameter int WORD_IDX_W = l1cp_pkg::WORD_IDX_W
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic debug_recovery_mode,
    input wire logic icache_enable,
    input wire logic dcache_enable,
    input wire logic [15:0] core_extended_control_reg,
    input wire logic fetch_valid,
    input wire logic fetch_cacheable,
    input wire logic fetch_device,
    input wire logic fetch_icache_hit,
    input wire logic [SET_W-1:0] fetch_set,
    input wire logic [WORD_IDX_W-1:0] fetch_word,
    input wire logic ls_valid,
    input wire logic ls_store,
    input wire logic ls_cacheable,
    input wire logic ls_hit,
    input wire logic [SET_W-1:0] ls_set,
    input wire logic [WAY_W-1:0] ls_way,
    input wire logic [WORD_IDX_W-1:0] ls_word,
    input wire logic full_line_pending,
    input wire logic full_line_zero_op,
    input wire logic no_resource,
    input wire logic fill_valid,
    input wire logic [SET_W-1:0] fill_set,
    input wire logic [WAY_W-1:0] fill_way,
    input wire logic fill_unique,
    input wire logic snoop_valid,
    input wire logic snoop_inval,
    input wire logic [SET_W-1:0] snoop_set,
    input wire logic [WAY_W-1:0] snoop_way,
    input wire logic mnt_valid,
    input wire logic [1:0] mnt_op,
    input wire logic mnt_aarch64,
    input wire logic [SET_W-1:0] mnt_set,
    input wire logic [WAY_W-1:0] mnt_way,
    input wire logic hyp_setway_inval_override,
    output logic init_busy,
    output logic icache_array_en,
    output logic dcache_array_en,
    output logic l2_array_en,
    output logic l3_array_en,
    output logic fetch_noncacheable,
    output logic fetch_dcache_lookup,
    output logic fetch_dcache_alloc,
    output logic fetch_l2l3_alloc,
    output logic ls_noncacheable,
    output logic req_valid,
    output logic [WORD_IDX_W-1:0] req_crit_word,
    output logic req_linefill,
    output logic store_write_through,
    output logic [1:0] stream_dest,
    output logic stream_mode,
    output logic mnt_clean,
    output logic mnt_inval,
    output logic mnt_perm_inval,
    output logic [1:0] mnt_line_state
);
    typedef struct packed
    {
        logic init_busy;
        logic [SET_W-1:0] init_set;
        logic rel_seen;
        logic icache_array_en;
        logic dcache_array_en;
        logic l2_array_en;
        logic l3_array_en;
        logic fetch_noncacheable;
        logic fetch_dcache_lookup;
        logic fetch_dcache_alloc;
        logic fetch_l2l3_alloc;
        logic ls_noncacheable;
        logic req_valid;
        logic [WORD_IDX_W-1:0] req_crit_word;
        logic req_linefill;
        logic store_write_through;
        logic [1:0] stream_dest;
        logic mnt_clean;
        logic mnt_inval;
        logic mnt_perm_inval;
        logic [1:0] mnt_line_state;
    } l1cp_st_t;

    l1cp_st_t st;
    l1cp_st_t next_st;
    // per-line coherence state, WAYS entries per set
    l1cp_pkg::l1cp_mesi_t mesi [SETS][1<<WAY_W];
    logic wsm_active;
    logic d_on;
    logic fetch_cached;
    logic [3:0] wsm_count;

    // thresholds: [3:0] count to L3, [7:4] count to system, [11:8] hit exit
    function automatic logic [1:0] l1cp_dest(input logic [3:0] cnt,
                                             input logic [15:0] ctl);
        if (cnt >= ctl[7:4])
            l1cp_dest = 2'(l1cp_pkg::L1CP_DEST_SYS);
        else if (cnt >= ctl[3:0])
            l1cp_dest = 2'(l1cp_pkg::L1CP_DEST_L3);
        else
            l1cp_dest = 2'(l1cp_pkg::L1CP_DEST_L2);
    endfunction : l1cp_dest

    function automatic logic l1cp_dirty(input l1cp_pkg::l1cp_mesi_t s);
        l1cp_dirty = (s == l1cp_pkg::L1CP_MOD);
    endfunction : l1cp_dirty

    l1cp_wsm u_wsm (
        .mclk(mclk),
        .arst_n(arst_n),
        .full_line_pending(full_line_pending),
        .linefill_busy(st.req_linefill),
        .full_line_zero_op(full_line_zero_op),
        .no_resource(no_resource),
        .store_valid(ls_valid && ls_store),
        .store_hit(ls_hit),
        .hit_exit(core_extended_control_reg[11:8]),
        .active(wsm_active)
    );

    // one enable covers L1 data and L2, sampled per request only
    assign d_on = dcache_enable && !st.init_busy;
    assign fetch_cached = icache_enable && !st.init_busy && fetch_cacheable
        && !fetch_device;

    always_comb
    begin
        next_st = st;
        next_st.req_valid = 1'b0;
        next_st.req_linefill = 1'b0;
        next_st.store_write_through = 1'b0;
        next_st.mnt_clean = 1'b0;
        next_st.mnt_inval = 1'b0;
        next_st.mnt_perm_inval = 1'b0;
        next_st.icache_array_en = 1'b0;
        next_st.dcache_array_en = 1'b0;
        next_st.l2_array_en = 1'b0;
        next_st.l3_array_en = 1'b0;
        next_st.fetch_dcache_lookup = 1'b0;
        next_st.fetch_dcache_alloc = 1'b0;
        next_st.fetch_l2l3_alloc = 1'b0;
        if (!st.rel_seen)
        begin
            next_st.rel_seen = 1'b1;
            next_st.init_busy = !debug_recovery_mode;
            next_st.init_set = '0;
        end
        else if (st.init_busy)
        begin
            next_st.icache_array_en = 1'b1;
            next_st.dcache_array_en = 1'b1;
            next_st.init_set = st.init_set + 1'b1;
            if (st.init_set == SET_W'(SETS - 1))
                next_st.init_busy = 1'b0;
        end
        if (fetch_valid && !st.init_busy)
        begin
            next_st.fetch_noncacheable = !fetch_cached;
            next_st.icache_array_en = fetch_cached;
            if (fetch_cached && !fetch_icache_hit)
            begin
                next_st.fetch_dcache_lookup = 1'b1;
                next_st.fetch_dcache_alloc = d_on;
                next_st.fetch_l2l3_alloc = d_on;
                next_st.req_valid = 1'b1;
                next_st.req_crit_word = fetch_word;
                next_st.req_linefill = 1'b1;
            end
        end
        if (ls_valid && !st.init_busy)
        begin
            next_st.ls_noncacheable = !(d_on && ls_cacheable);
            next_st.dcache_array_en = d_on && ls_cacheable;
            next_st.l2_array_en = d_on && ls_cacheable;
            next_st.l3_array_en = d_on && ls_cacheable;
            next_st.req_valid = !(d_on && ls_cacheable && ls_hit);
            next_st.req_crit_word = ls_word;
            if (d_on && ls_cacheable && !ls_hit)
            begin
                if (ls_store && wsm_active)
                begin
                    next_st.store_write_through = 1'b1;
                    next_st.stream_dest =
                        l1cp_dest(wsm_count, core_extended_control_reg);
                end
                else
                    next_st.req_linefill = 1'b1;
            end
        end
        // maintenance ignores both enables
        if (mnt_valid)
        begin
            next_st.dcache_array_en = 1'b1;
            next_st.icache_array_en = 1'b1;
            next_st.mnt_inval = 1'b1;
            next_st.mnt_line_state = 2'(mesi[mnt_set][mnt_way]);
            unique case (l1cp_pkg::l1cp_mnt_t'(mnt_op))
                l1cp_pkg::L1CP_MNT_INVAL_ADDR:
                begin
                    next_st.mnt_clean = mnt_aarch64
                        || l1cp_dirty(mesi[mnt_set][mnt_way]);
                    next_st.mnt_perm_inval = 1'b1;
                end
                l1cp_pkg::L1CP_MNT_CLEAN_INVAL_ADDR:
                    next_st.mnt_clean = 1'b1;
                l1cp_pkg::L1CP_MNT_INVAL_ADDR32:
                begin
                    next_st.mnt_clean =
                        l1cp_dirty(mesi[mnt_set][mnt_way]);
                    next_st.mnt_perm_inval = 1'b1;
                end
                l1cp_pkg::L1CP_MNT_INVAL_SETWAY:
                    next_st.mnt_clean = 1'b1
                        || hyp_setway_inval_override;
            endcase
        end
    end

    // streaming depth counter picks the destination tier
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wsm_count <= '0;
        else if (!wsm_active)
            wsm_count <= '0;
        else if (ls_valid && ls_store && !ls_hit && wsm_count != 4'hF)
            wsm_count <= wsm_count + 1'b1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // coherence array; enable changes leave it untouched
    always_ff @(posedge mclk)
    begin
        if (st.init_busy)
        begin
            for (int w = 0; w < (1 << WAY_W); w++)
                mesi[st.init_set][w] <= l1cp_pkg::L1CP_INVALID;
        end
        else
        begin
            if (fill_valid)
                mesi[fill_set][fill_way] <= fill_unique ?
                    l1cp_pkg::L1CP_EXCL : l1cp_pkg::L1CP_SHARED;
            if (ls_valid && ls_store && ls_hit && d_on && ls_cacheable)
                mesi[ls_set][ls_way] <= l1cp_pkg::L1CP_MOD;
            if (snoop_valid)
                mesi[snoop_set][snoop_way] <= snoop_inval ?
                    l1cp_pkg::L1CP_INVALID : l1cp_pkg::L1CP_SHARED;
            if (mnt_valid)
                mesi[mnt_set][mnt_way] <= l1cp_pkg::L1CP_INVALID;
        end
    end

    assign init_busy = st.init_busy;
    assign icache_array_en = st.icache_array_en;
    assign dcache_array_en = st.dcache_array_en;
    assign l2_array_en = st.l2_array_en;
    assign l3_array_en = st.l3_array_en;
    assign fetch_noncacheable = st.fetch_noncacheable;
    assign fetch_dcache_lookup = st.fetch_dcache_lookup;
    assign fetch_dcache_alloc = st.fetch_dcache_alloc;
    assign fetch_l2l3_alloc = st.fetch_l2l3_alloc;
    assign ls_noncacheable = st.ls_noncacheable;
    assign req_valid = st.req_valid;
    assign req_crit_word = st.req_crit_word;
    assign req_linefill = st.req_linefill;
    assign store_write_through = st.store_write_through;
    assign stream_dest = st.stream_dest;
    assign stream_mode = wsm_active;
    assign mnt_clean = st.mnt_clean;
    assign mnt_inval = st.mnt_inval;
    assign mnt_perm_inval = st.mnt_perm_inval;
    assign mnt_line_state = st.mnt_line_state;
endmodule : l1cp_top

// [dv/l1cp_checker.sv]
// port assertions for the l1 cache policy controller
`timescale 1ns/10ps
module l1cp_checker #(
    parameter int WORD_IDX_W = l1cp_pkg::WORD_IDX_W
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic icache_enable,
    input wire logic dcache_enable,
    input wire logic fetch_valid,
    input wire logic fetch_cacheable,
    input wire logic fetch_device,
    input wire logic fetch_icache_hit,
    input wire logic ls_valid,
    input wire logic ls_store,
    input wire logic ls_cacheable,
    input wire logic ls_hit,
    input wire logic [WORD_IDX_W-1:0] ls_word,
    input wire logic mnt_valid,
    input wire logic [1:0] mnt_op,
    input wire logic mnt_aarch64,
    input wire logic init_busy,
    input wire logic icache_array_en,
    input wire logic dcache_array_en,
    input wire logic l2_array_en,
    input wire logic l3_array_en,
    input wire logic fetch_noncacheable,
    input wire logic fetch_dcache_lookup,
    input wire logic fetch_dcache_alloc,
    input wire logic fetch_l2l3_alloc,
    input wire logic ls_noncacheable,
    input wire logic [WORD_IDX_W-1:0] req_crit_word,
    input wire logic req_linefill,
    input wire logic store_write_through,
    input wire logic stream_mode,
    input wire logic mnt_clean,
    input wire logic mnt_inval,
    input wire logic mnt_perm_inval,
    input wire logic [1:0] mnt_line_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire f_go = fetch_valid && !init_busy;
    wire l_go = ls_valid && !init_busy;
    wire l_miss = l_go && ls_cacheable && dcache_enable && !ls_hit;

    property p_init;
        $rose(init_busy) |=> init_busy [*8];
    endproperty
    a_init: assert property (p_init) else $error("init cut short");
    property p_ic_off;
        f_go && fetch_cacheable && !icache_enable |=> fetch_noncacheable;
    endproperty
    a_ic_off: assert property (p_ic_off) else $error("fetch cached");
    property p_dev;
        f_go && fetch_device |=> fetch_noncacheable;
    endproperty
    a_dev: assert property (p_dev) else $error("device fetch cached");
    property p_ic_alloc;
        f_go && icache_enable && !fetch_icache_hit && !dcache_enable
            |=> !fetch_dcache_alloc;
    endproperty
    a_ic_alloc: assert property (p_ic_alloc) else $error("bad alloc");
    property p_dc_off;
        l_go && ls_cacheable && !dcache_enable && !mnt_valid && !fetch_valid
            |=> ls_noncacheable && !dcache_array_en;
    endproperty
    a_dc_off: assert property (p_dc_off)
        else $error("dcache used");
    property p_fill;
        l_miss && !(ls_store && stream_mode)
            |=> req_linefill && req_crit_word == $past(ls_word);
    endproperty
    a_fill: assert property (p_fill)
        else $error("linefill wrong");
    property p_stream;
        l_miss && ls_store && stream_mode
            |=> store_write_through && !req_linefill;
    endproperty
    a_stream: assert property (p_stream) else $error("stream store");
    property p_mnt;
        mnt_valid && (mnt_op == 2'h3 || mnt_op == 2'h0 && mnt_aarch64)
            |=> mnt_clean && mnt_inval;
    endproperty
    a_mnt: assert property (p_mnt) else $error("no clean");
    property p_mnt_arr;
        mnt_valid |=> mnt_inval && icache_array_en && dcache_array_en;
    endproperty
    a_mnt_arr: assert property (p_mnt_arr)
        else $error("maintenance arrays off");
    property p_perm;
        mnt_valid && (mnt_op == 2'h0 || mnt_op == 2'h2) |=> mnt_perm_inval;
    endproperty
    a_perm: assert property (p_perm)
        else $error("invalidate checks lost");
    property p_dirty;
        mnt_valid && mnt_op == 2'h2 |=> mnt_clean == (mnt_line_state == 2'h3);
    endproperty
    a_dirty: assert property (p_dirty)
        else $error("dirty line not cleaned");
    property p_ic_miss;
        f_go && icache_enable && fetch_cacheable && !fetch_device
            && !fetch_icache_hit
            |=> fetch_dcache_lookup
                && fetch_l2l3_alloc == $past(dcache_enable);
    endproperty
    a_ic_miss: assert property (p_ic_miss)
        else $error("fetch miss lookup");
    property p_ic_arr;
        f_go && !icache_enable && !mnt_valid |=> !icache_array_en;
    endproperty
    a_ic_arr: assert property (p_ic_arr)
        else $error("icache array used");
    property p_l2_off;
        l_go && !dcache_enable |=> !l2_array_en && !l3_array_en;
    endproperty
    a_l2_off: assert property (p_l2_off)
        else $error("lower arrays used");
endmodule : l1cp_checker

// [dv/l1cp_l2_model.sv]
// next level model: answers the latest linefill request with a fill; a newer request restarts the wait
`timescale 1ns/10ps
module l1cp_l2_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic req_linefill,
    input wire logic slow,
    input wire logic excl,
    input wire logic [7:0] req_line,
    output logic fill_valid,
    output logic [7:0] fill_line,
    output logic fill_unique
);
    logic [2:0] dly;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dly <= 3'h0;
            fill_valid <= 1'b0;
            fill_line <= 8'h00;
            fill_unique <= 1'b0;
        end
        else
        begin
            fill_valid <= dly == 3'h1;
            fill_unique <= excl;
            if (req_linefill)
                fill_line <= req_line;
            else if (dly == 3'h0)
                fill_line <= ~fill_line;
            if (req_linefill)
                dly <= slow ? 3'h4 : 3'h1;
            else if (dly != 3'h0)
                dly <= dly - 3'h1;
        end
    end
endmodule : l1cp_l2_model

// [dv/l1cp_top_test.sv]
// self-checking bench for the l1 cache policy controller
`timescale 1ns/10ps
module l1cp_top_test;
    logic mclk, arst_n, debug_recovery_mode, icache_enable, dcache_enable, e;
    logic fetch_valid, fetch_cacheable, fetch_device, fetch_icache_hit;
    logic ls_valid, ls_store, ls_cacheable, ls_hit, full_line_pending;
    logic full_line_zero_op, no_resource, snoop_valid, snoop_inval, excl;
    logic mnt_valid, mnt_aarch64, hyp_setway_inval_override, slow, mnt_clean;
    logic fill_valid, fill_unique, init_busy, icache_array_en, l2_array_en;
    logic dcache_array_en, l3_array_en, fetch_noncacheable, ls_noncacheable;
    logic fetch_dcache_lookup, fetch_dcache_alloc, fetch_l2l3_alloc;
    logic req_valid, req_linefill, store_write_through, stream_mode;
    logic mnt_inval, mnt_perm_inval;
    logic [15:0] core_extended_control_reg;
    logic [l1cp_pkg::SET_W-1:0] fetch_set, ls_set, fill_set, snoop_set;
    logic [l1cp_pkg::SET_W-1:0] mnt_set;
    logic [l1cp_pkg::WAY_W-1:0] ls_way, fill_way, snoop_way, mnt_way;
    logic [l1cp_pkg::WORD_IDX_W-1:0] fetch_word, ls_word, req_crit_word, w;
    logic [1:0] mnt_op, stream_dest, mnt_line_state;
    logic [3:0] ftab [4] = '{4'h5, 4'hF, 4'hC, 4'hC};
    integer seed, n;
    int miscompares, num_checks;
    logic [5:0] rq_q [$];
    logic mq_q [$];
    wire [5:0] req_seen = {req_valid, req_linefill, store_write_through,
        req_linefill ? req_crit_word : 3'h0};

    l1cp_top u_l1cp_top (.*);
    l1cp_l2_model u_l1cp_l2_model (.mclk, .arst_n, .req_linefill, .slow,
        .excl, .req_line({ls_set, ls_way}), .fill_valid,
        .fill_line({fill_set, fill_way}), .fill_unique);

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [5:0] x,
                       input logic [5:0] s);
        num_checks++;
        if (s !== x)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic end_sim;
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick

    // pulse for one taken edge, then one idle cycle
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick;
        s = 1'b0;
        tick;
    endtask : pulse

    task automatic ls_op(input logic st, input logic hit,
                         input logic [2:0] wd);
        {ls_set, ls_way, slow, excl} = 10'($random(seed));
        {ls_store, ls_hit, ls_word} = {st, hit, wd};
        pulse(ls_valid);
    endtask : ls_op

    task automatic do_reset(input logic dbg);
        int i;
        debug_recovery_mode = dbg;
        arst_n = 1'b0;
        repeat (3) tick;
        arst_n = 1'b1;
        tick;
        chk("init_busy", 6'(!dbg), 6'(init_busy));
        ls_op(1'b0, 1'b0, 3'h3);
        for (i = 0; i < 80 && init_busy !== 1'b0; i++)
            tick;
        if (init_busy !== 1'b0)
        begin
            miscompares++;
            end_sim;
        end
    endtask : do_reset

    // every linefill or streamed store must match the oldest note
    always @(negedge mclk)
    begin
        if (req_linefill === 1'b1 || store_write_through === 1'b1)
            chk("req", rq_q.size() != 0 ? rq_q.pop_front() : 6'h3F,
                req_seen);
        if (mnt_inval === 1'b1 && mq_q.size() != 0)
            chk("mnt_clean", 6'(mq_q.pop_front()), 6'(mnt_clean));
    end

    initial
    begin
        seed = 32'h5543D8AC;
        {fetch_valid, fetch_cacheable, fetch_device, fetch_icache_hit} = 4'h0;
        {ls_valid, ls_store, ls_hit, full_line_pending} = 4'h0;
        {full_line_zero_op, no_resource, snoop_valid, snoop_inval} = 4'h0;
        {mnt_valid, mnt_aarch64, hyp_setway_inval_override, slow} = 4'h0;
        {excl, icache_enable, dcache_enable, ls_cacheable} = 4'h3;
        {fetch_set, ls_set, snoop_set, mnt_set} = 24'h000000;
        {ls_way, snoop_way, mnt_way, mnt_op, fetch_word, ls_word} = 14'h0000;
        // low store-hit exit count so the hit path is reachable
        core_extended_control_reg = 16'h0221;
        do_reset(1'b0);
        for (n = 0; n < 8; n++)
        begin
            w = 3'($random(seed));
            rq_q.push_back({3'b110, w});
            ls_op(n[0], 1'b0, w);
        end
        pulse(full_line_zero_op);
        chk("stream_mode", 6'h01, 6'(stream_mode));
        // second streamed miss sits one deeper: moves from L2 to L3 tier
        for (n = 0; n < 2; n++)
        begin
            rq_q.push_back(6'h28);
            ls_op(1'b1, 1'b0, w);
            chk("stream_dest", 6'(n), 6'(stream_dest));
        end
        rq_q.push_back({3'b110, w});
        ls_op(1'b0, 1'b0, w);
        repeat (4) ls_op(1'b1, 1'b1, w);
        chk("stream_mode", 6'h00, 6'(stream_mode));
        full_line_pending = 1'b1;
        rq_q.push_back({3'b110, w});
        ls_op(1'b0, 1'b0, w);
        full_line_pending = 1'b0;
        tick;
        chk("stream_mode", 6'h01, 6'(stream_mode));
        pulse(no_resource);
        chk("stream_mode", 6'h00, 6'(stream_mode));
        dcache_enable = 1'b0;
        for (n = 0; n < 2; n++)
        begin
            ls_cacheable = n[0];
            ls_op(1'b0, 1'b0, w);
            chk("ls_nc", 6'h01, 6'(ls_noncacheable));
        end
        for (n = 0; n < 4; n++)
        begin
            {icache_enable, fetch_cacheable, fetch_device, e} = ftab[n];
            {fetch_set, fetch_word} = 9'($random(seed));
            dcache_enable = n == 3;
            if (!e)
                rq_q.push_back({3'b110, fetch_word});
            pulse(fetch_valid);
            chk("fetch_nc", 6'(e), 6'(fetch_noncacheable));
        end
        dcache_enable = 1'b0;
        for (n = 0; n < 4; n++)
        begin
            {mnt_set, mnt_way, hyp_setway_inval_override} = 9'($random(seed));
            mnt_op = n[1:0];
            mnt_aarch64 = n != 2;
            if (n != 2)
                mq_q.push_back(1'b1);
            pulse(mnt_valid);
        end
        do_reset(1'b1);
        chk("pending", 6'h00, 6'(rq_q.size() + mq_q.size()));
        end_sim;
    end

    initial
    begin
        #2000000;
        miscompares++;
        end_sim;
    end
endmodule : l1cp_top_test

bind l1cp_top l1cp_checker #(.WORD_IDX_W(WORD_IDX_W)) u_l1cp_checker (.*);
